// [rtl/debug_event_recognition.sv]
// debug event recognition: event qualification, status and save address
// =========================================================================
// Behaviour
// - completion event needs its enable, a completed insn, and allow or halt
// - a suppressed insn with another enabled exception raises no completion
// - a system call counts as executed and raises the completion event
// - completion sets its flag and saves the next instruction address
// - no completion event when allow and halt mode are both low, except a rounding exception in internal mode
// - rounding exception with completion enabled sets it plus imprecise
// - the rounding case applies in internal or external halt mode
// - insn enabling allow or the completion enable raises no completion
// - non-critical interrupt sets its flag and saves its handler address
// - critical interrupt sets its flag, saves handler; not debug w/o set
// - normal return attempt sets the normal return flag
// - critical return attempt sets the critical return flag
// - return events also set imprecise when allow and halt both low
// - normal return with allow takes debug irq, saves the return address
// - critical return with allow takes debug irq, saves its address
// - counter events set their flag when the counter reaches zero
// - external pins set their flag on asserting edges when enabled
// - forced pin edge sets its flag in internal or halt mode
// - non-completion events record regardless of allow
`timescale 1ns/1ps
`default_nettype none

module debug_event_recognition (
   // clock and reset
   input  wire logic                           clk_sys_i,
   input  wire logic                           rst_i,
   // configuration and mode
   input  wire logic [dbg_evt_pkg::CTRL_W-1:0] dbg_ctrl0_i,
   input  wire logic                           dbg_irq_allow_i,
   input  wire logic                           external_halt_mode_i,
   input  wire logic                           internal_dbg_mode_i,
   input  wire logic                           dbg_insn_set_en_i,
   // instruction completion from the pipeline
   input  wire logic                           insn_done_i,
   input  wire logic                           insn_suppressed_i,
   input  wire logic                           system_call_insn_i,
   input  wire logic                           insn_sets_irq_allow_i,
   input  wire logic                           insn_sets_compl_en_i,
   input  wire logic [dbg_evt_pkg::PC_W-1:0]   next_pc_i,
   input  wire logic                           fp_round_exc_i,
   input  wire logic [dbg_evt_pkg::PC_W-1:0]   round_handler_pc_i,
   // interrupts taken
   input  wire logic                           nc_intr_i,
   input  wire logic [dbg_evt_pkg::PC_W-1:0]   nc_handler_pc_i,
   input  wire logic                           crit_intr_i,
   input  wire logic                           crit_is_dbg_i,
   input  wire logic [dbg_evt_pkg::PC_W-1:0]   crit_handler_pc_i,
   // return attempts
   input  wire logic                           intr_return_i,
   input  wire logic                           crit_return_i,
   input  wire logic [dbg_evt_pkg::PC_W-1:0]   ret_pc_i,
   input  wire logic                           higher_exc_i,
   // debug counters
   input  wire logic                           cnt1_on_i,
   input  wire logic                           cnt2_on_i,
   input  wire logic                           cnt1_zero_i,
   input  wire logic                           cnt2_zero_i,
   // external pins, asynchronous
   input  wire logic                           ext_evt_pin1_i,
   input  wire logic                           ext_evt_pin2_i,
   input  wire logic                           forced_evt_pin_i,
   // software clear, one bit per flag
   input  wire logic [dbg_evt_pkg::STS_W-1:0]  status_clr_i,
   // results
   output logic      [dbg_evt_pkg::STS_W-1:0]  dbg_status_o,
   output logic      [dbg_evt_pkg::PC_W-1:0]   dbg_save_pc_o,
   output logic                                dbg_take_o
);

   // =====================================================================
   // pin edges
   logic [dbg_evt_pkg::PIN_W-1:0] pin_rise;

   pin_edge_sync u_pins (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .pin_i     ({forced_evt_pin_i, ext_evt_pin2_i, ext_evt_pin1_i}),
      .rise_o    (pin_rise)
   );

   // =====================================================================
   // event qualification
   logic                          mode_ok;
   logic                          halt_any;
   logic                          executed;
   logic                          self_enable;
   logic                          compl_evt;
   logic                          round_evt;
   logic                          crit_evt;
   logic                          ret_evt;
   logic                          crit_ret_evt;
   logic                          ret_imprec;
   logic                          ret_take;
   logic [dbg_evt_pkg::STS_W-1:0] sts_set;

   always_comb begin
      mode_ok  = dbg_irq_allow_i | external_halt_mode_i;
      halt_any = internal_dbg_mode_i | external_halt_mode_i;
      // a system call executes and is never suppressed
      executed = insn_done_i &
                 (~insn_suppressed_i | system_call_insn_i);
      self_enable =
         (insn_sets_irq_allow_i & dbg_ctrl0_i[dbg_evt_pkg::EN_COMPL]) |
         (insn_sets_compl_en_i & mode_ok);
      compl_evt = dbg_ctrl0_i[dbg_evt_pkg::EN_COMPL] & executed &
                  mode_ok & ~self_enable;
      round_evt = dbg_ctrl0_i[dbg_evt_pkg::EN_COMPL] & fp_round_exc_i &
                  halt_any;
      crit_evt = dbg_ctrl0_i[dbg_evt_pkg::EN_CRIT_INTR] & crit_intr_i &
                 ~(crit_is_dbg_i & ~dbg_insn_set_en_i);
      ret_evt  = dbg_ctrl0_i[dbg_evt_pkg::EN_RET] & intr_return_i;
      crit_ret_evt = dbg_ctrl0_i[dbg_evt_pkg::EN_CRIT_RET] & crit_return_i;
      // mode is sampled before the return rewrites the machine state
      ret_imprec = (ret_evt | crit_ret_evt) & ~mode_ok;
      ret_take   = (ret_evt | crit_ret_evt) & dbg_irq_allow_i &
                   ~higher_exc_i;

      sts_set = dbg_evt_pkg::STS_RST;
      sts_set[dbg_evt_pkg::ST_COMPL] = compl_evt | round_evt;
      sts_set[dbg_evt_pkg::ST_INTR]  =
         dbg_ctrl0_i[dbg_evt_pkg::EN_INTR] & nc_intr_i;
      sts_set[dbg_evt_pkg::ST_CRIT_INTR] = crit_evt;
      sts_set[dbg_evt_pkg::ST_RET]   = ret_evt;
      sts_set[dbg_evt_pkg::ST_CRIT_RET] = crit_ret_evt;
      sts_set[dbg_evt_pkg::ST_CNT1]  = dbg_ctrl0_i[dbg_evt_pkg::EN_CNT1] &
                                       cnt1_on_i & cnt1_zero_i;
      sts_set[dbg_evt_pkg::ST_CNT2]  = dbg_ctrl0_i[dbg_evt_pkg::EN_CNT2] &
                                       cnt2_on_i & cnt2_zero_i;
      sts_set[dbg_evt_pkg::ST_PIN1]  = dbg_ctrl0_i[dbg_evt_pkg::EN_PIN1] &
         pin_rise[dbg_evt_pkg::PIN_EXT1];
      sts_set[dbg_evt_pkg::ST_PIN2]  = dbg_ctrl0_i[dbg_evt_pkg::EN_PIN2] &
         pin_rise[dbg_evt_pkg::PIN_EXT2];
      sts_set[dbg_evt_pkg::ST_FORCED] =
         pin_rise[dbg_evt_pkg::PIN_FORCED] & halt_any;
      sts_set[dbg_evt_pkg::ST_IMPREC] = round_evt | ret_imprec;
   end

   // =====================================================================
   // sticky flags
   status_flags u_flags (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .set_i     (sts_set),
      .clr_i     (status_clr_i),
      .flags_o   (dbg_status_o)
   );

   // =====================================================================
   // save address: returns outrank completion, which outranks interrupts;
   // only one address fits, so lower sources are lost in a shared cycle
   dbg_evt_pkg::pc_src_t          pc_src;
   logic [dbg_evt_pkg::PC_W-1:0]  save_pc_reg;
   logic [dbg_evt_pkg::PC_W-1:0]  save_pc_next;
   logic                          take_reg;
   logic                          take_next;

   always_comb begin
      if (ret_take) begin
         pc_src = dbg_evt_pkg::PC_RET_INSN;
      end else if (round_evt) begin
         pc_src = dbg_evt_pkg::PC_ROUND_HANDLER;
      end else if (compl_evt) begin
         pc_src = dbg_evt_pkg::PC_NEXT_INSN;
      end else if (crit_evt) begin
         pc_src = dbg_evt_pkg::PC_CRIT_HANDLER;
      end else if (sts_set[dbg_evt_pkg::ST_INTR]) begin
         pc_src = dbg_evt_pkg::PC_NC_HANDLER;
      end else begin
         pc_src = dbg_evt_pkg::PC_HOLD;
      end
      unique case (pc_src)
         dbg_evt_pkg::PC_RET_INSN:      save_pc_next = ret_pc_i;
         dbg_evt_pkg::PC_ROUND_HANDLER: save_pc_next = round_handler_pc_i;
         dbg_evt_pkg::PC_NEXT_INSN:     save_pc_next = next_pc_i;
         dbg_evt_pkg::PC_CRIT_HANDLER:  save_pc_next = crit_handler_pc_i;
         dbg_evt_pkg::PC_NC_HANDLER:    save_pc_next = nc_handler_pc_i;
         dbg_evt_pkg::PC_HOLD:          save_pc_next = save_pc_reg;
      endcase
      take_next = compl_evt | round_evt | ret_take;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         save_pc_reg <= dbg_evt_pkg::PC_RST;
         take_reg    <= 1'b0;
      end else begin
         save_pc_reg <= save_pc_next;
         take_reg    <= take_next;
      end
   end

   assign dbg_save_pc_o = save_pc_reg;
   assign dbg_take_o    = take_reg;

   // =====================================================================
   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence s_done_ok;
      dbg_ctrl0_i[dbg_evt_pkg::EN_COMPL] && insn_done_i &&
      !insn_suppressed_i && mode_ok && !self_enable;
   endsequence

   sequence s_plain_done;
      s_done_ok ##0 (!ret_take && !round_evt);
   endsequence

   // a pin edge needs three clock edges through synchroniser and detector
   sequence s_pin1_rise;
      $rose(ext_evt_pin1_i) && dbg_ctrl0_i[dbg_evt_pkg::EN_PIN1] ##1
      dbg_ctrl0_i[dbg_evt_pkg::EN_PIN1] [*2];
   endsequence

   sequence s_forced_rise;
      $rose(forced_evt_pin_i) && halt_any ##1 halt_any [*2];
   endsequence

   a_compl_sets_flag: assert property (
      s_done_ok |=> dbg_status_o[dbg_evt_pkg::ST_COMPL])
      else $error("completion flag not set");
   a_compl_save_pc: assert property (
      s_plain_done |=> dbg_save_pc_o == $past(next_pc_i) && dbg_take_o)
      else $error("completion save address wrong");
   a_syscall_done: assert property (
      dbg_ctrl0_i[dbg_evt_pkg::EN_COMPL] && insn_done_i &&
      system_call_insn_i && mode_ok && !self_enable
      |=> dbg_status_o[dbg_evt_pkg::ST_COMPL])
      else $error("system call completion not recorded");
   a_compl_no_mode: assert property (
      !mode_ok && !round_evt |=> !dbg_take_o || $past(ret_take))
      else $error("completion taken without mode");
   a_suppressed_none: assert property (
      insn_suppressed_i && !system_call_insn_i && !round_evt &&
      !ret_take |=> !dbg_take_o)
      else $error("suppressed insn raised completion");
   a_self_enable_none: assert property (
      self_enable && !round_evt && !ret_take |=> !dbg_take_o)
      else $error("self enabling insn raised completion");
   a_round_imprecise: assert property (
      round_evt |=> dbg_status_o[dbg_evt_pkg::ST_IMPREC] &&
      dbg_status_o[dbg_evt_pkg::ST_COMPL])
      else $error("rounding case flags missing");
   a_ret_imprecise: assert property (
      (ret_evt || crit_ret_evt) && !dbg_irq_allow_i && !external_halt_mode_i
      |=> dbg_status_o[dbg_evt_pkg::ST_IMPREC])
      else $error("return imprecise flag missing");
   a_ret_take_pc: assert property (
      ret_evt && dbg_irq_allow_i && !higher_exc_i
      |=> dbg_take_o && dbg_save_pc_o == $past(ret_pc_i))
      else $error("return debug irq wrong");
   a_crit_ret_take: assert property (
      crit_return_i && dbg_ctrl0_i[dbg_evt_pkg::EN_CRIT_RET] &&
      dbg_irq_allow_i && !higher_exc_i
      |=> dbg_take_o && dbg_save_pc_o == $past(ret_pc_i))
      else $error("critical return debug irq wrong");
   a_exit_flag: assert property (
      intr_return_i && dbg_ctrl0_i[dbg_evt_pkg::EN_RET]
      |=> dbg_status_o[dbg_evt_pkg::ST_RET])
      else $error("return event not recorded");
   a_crit_exit_flag: assert property (
      crit_return_i && dbg_ctrl0_i[dbg_evt_pkg::EN_CRIT_RET]
      |=> dbg_status_o[dbg_evt_pkg::ST_CRIT_RET])
      else $error("critical return not recorded");
   a_crit_dbg_block: assert property (
      crit_intr_i && crit_is_dbg_i && !dbg_insn_set_en_i &&
      !dbg_status_o[dbg_evt_pkg::ST_CRIT_INTR]
      |=> !dbg_status_o[dbg_evt_pkg::ST_CRIT_INTR])
      else $error("debug irq set critical flag");
   a_crit_sets_flag: assert property (
      crit_intr_i && dbg_ctrl0_i[dbg_evt_pkg::EN_CRIT_INTR] &&
      dbg_insn_set_en_i |=> dbg_status_o[dbg_evt_pkg::ST_CRIT_INTR])
      else $error("critical interrupt not recorded");
   a_intr_save_pc: assert property (
      nc_intr_i && dbg_ctrl0_i[dbg_evt_pkg::EN_INTR] && !ret_take &&
      !round_evt && !compl_evt && !crit_evt
      |=> dbg_save_pc_o == $past(nc_handler_pc_i))
      else $error("interrupt save address wrong");
   a_flag_sticky: assert property (
      dbg_status_o[dbg_evt_pkg::ST_INTR] &&
      !status_clr_i[dbg_evt_pkg::ST_INTR]
      |=> dbg_status_o[dbg_evt_pkg::ST_INTR])
      else $error("flag dropped without clear");
   a_counter_flag: assert property (
      dbg_ctrl0_i[dbg_evt_pkg::EN_CNT2] && cnt2_on_i && cnt2_zero_i
      |=> dbg_status_o[dbg_evt_pkg::ST_CNT2])
      else $error("counter event not recorded");
   a_pin_edge_flag: assert property (
      s_pin1_rise |=> dbg_status_o[dbg_evt_pkg::ST_PIN1])
      else $error("pin edge not recorded");
   a_forced_edge: assert property (
      s_forced_rise |=> dbg_status_o[dbg_evt_pkg::ST_FORCED])
      else $error("forced pin edge not recorded");
   a_intr_any_mode: assert property (
      nc_intr_i && dbg_ctrl0_i[dbg_evt_pkg::EN_INTR] && !dbg_irq_allow_i
      |=> dbg_status_o[dbg_evt_pkg::ST_INTR])
      else $error("interrupt event lost without allow");

endmodule // debug_event_recognition

`default_nettype wire

// [rtl/dbg_evt_pkg.sv]
// shared constants for the debug event recognition block
package dbg_evt_pkg;

   // =====================================================================
   // widths
   localparam int PC_W   = 32;
   localparam int CTRL_W = 9;
   localparam int STS_W  = 11;
   localparam int PIN_W  = 3;

   // =====================================================================
   // event enable positions in dbg_ctrl0
   localparam int EN_COMPL     = 0;
   localparam int EN_INTR      = 1;
   localparam int EN_CRIT_INTR = 2;
   localparam int EN_RET       = 3;
   localparam int EN_CRIT_RET  = 4;
   localparam int EN_CNT1      = 5;
   localparam int EN_CNT2      = 6;
   localparam int EN_PIN1      = 7;
   localparam int EN_PIN2      = 8;

   // =====================================================================
   // flag positions in dbg_status
   localparam int ST_COMPL     = 0;
   localparam int ST_INTR      = 1;
   localparam int ST_CRIT_INTR = 2;
   localparam int ST_RET       = 3;
   localparam int ST_CRIT_RET  = 4;
   localparam int ST_CNT1      = 5;
   localparam int ST_CNT2      = 6;
   localparam int ST_PIN1      = 7;
   localparam int ST_PIN2      = 8;
   localparam int ST_FORCED    = 9;
   localparam int ST_IMPREC    = 10;

   // =====================================================================
   // pin positions on the sampled pin vector
   localparam int PIN_EXT1   = 0;
   localparam int PIN_EXT2   = 1;
   localparam int PIN_FORCED = 2;

   // =====================================================================
   // reset values
   localparam logic [STS_W-1:0] STS_RST = 11'h000;
   localparam logic [PC_W-1:0]  PC_RST  = 32'h0000_0000;
   localparam logic [PIN_W-1:0] PIN_RST = 3'h0;

   // =====================================================================
   // source of the captured save address
   typedef enum {
      PC_HOLD,
      PC_NEXT_INSN,
      PC_ROUND_HANDLER,
      PC_RET_INSN,
      PC_CRIT_HANDLER,
      PC_NC_HANDLER
   } pc_src_t;

endpackage

// [rtl/pin_edge_sync.sv]
// two-flop synchronisers and rising edge detectors for the debug pins
`timescale 1ns/1ps
`default_nettype none

module pin_edge_sync (
   // clock and reset
   input  wire logic                      clk_sys_i,
   input  wire logic                      rst_i,
   // raw asynchronous pins
   input  wire logic [dbg_evt_pkg::PIN_W-1:0] pin_i,
   // one-cycle pulse per asserting transition
   output logic      [dbg_evt_pkg::PIN_W-1:0] rise_o
);

   // =====================================================================
   // synchroniser chain
   logic [dbg_evt_pkg::PIN_W-1:0] meta_reg;
   logic [dbg_evt_pkg::PIN_W-1:0] sync_reg;
   logic [dbg_evt_pkg::PIN_W-1:0] prev_reg;
   logic [dbg_evt_pkg::PIN_W-1:0] meta_next;
   logic [dbg_evt_pkg::PIN_W-1:0] sync_next;
   logic [dbg_evt_pkg::PIN_W-1:0] prev_next;

   always_comb begin
      meta_next = pin_i;
      sync_next = meta_reg;
      prev_next = sync_reg;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg <= dbg_evt_pkg::PIN_RST;
         sync_reg <= dbg_evt_pkg::PIN_RST;
         prev_reg <= dbg_evt_pkg::PIN_RST;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   // =====================================================================
   // edges only: a pin held high raises one event, not one per cycle
   genvar g;
   generate
      for (g = 0; g < dbg_evt_pkg::PIN_W; g++) begin : g_edge
         assign rise_o[g] = sync_reg[g] & ~prev_reg[g];
      end
   endgenerate

endmodule // pin_edge_sync

`default_nettype wire

// [rtl/status_flags.sv]
// bank of sticky status flags, hardware set wins over software clear
`timescale 1ns/1ps
`default_nettype none

module status_flags (
   // clock and reset
   input  wire logic                          clk_sys_i,
   input  wire logic                          rst_i,
   // set and clear pulses
   input  wire logic [dbg_evt_pkg::STS_W-1:0] set_i,
   input  wire logic [dbg_evt_pkg::STS_W-1:0] clr_i,
   // flag state
   output logic      [dbg_evt_pkg::STS_W-1:0] flags_o
);

   // =====================================================================
   // per-flag next value
   logic [dbg_evt_pkg::STS_W-1:0] flags_reg;
   logic [dbg_evt_pkg::STS_W-1:0] flags_next;

   genvar g;
   generate
      for (g = 0; g < dbg_evt_pkg::STS_W; g++) begin : g_flag
         // a set in the clearing cycle is kept
         assign flags_next[g] = set_i[g] | (flags_reg[g] & ~clr_i[g]);
      end
   endgenerate

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         flags_reg <= dbg_evt_pkg::STS_RST;
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign flags_o = flags_reg;

endmodule // status_flags

`default_nettype wire

// [test/dbg_pin_driver.sv]
// far side model: drives the asynchronous debug event pins
`timescale 1ns/1ps
`default_nettype none

module dbg_pin_driver (
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   // one-cycle requests from the bench, one bit per pin
   input  wire logic [2:0] req_i,
   // pins, active high
   output logic      [2:0] pin_o
);
   // =====================================================================
   // pin pulses
   // a pin stays high six cycles so that a long level is seen by the block
   logic [2:0] hold_reg [3];

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pin_o    <= 3'h0;
         hold_reg <= '{default: 3'h0};
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (req_i[i]) begin
               pin_o[i]    <= 1'b1;
               hold_reg[i] <= 3'h5;
            end else if (hold_reg[i] != 3'h0) begin
               hold_reg[i] <= hold_reg[i] - 3'h1;
            end else begin
               pin_o[i] <= 1'b0;
            end
         end
      end
   end
endmodule // dbg_pin_driver

`default_nettype wire

// [test/debug_event_recognition_bench.sv]
// self-checking bench for the debug event recognition block
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   mismatches++; $display("ERROR %s exp %h got %h", n, e, g); end end

module debug_event_recognition_bench;
   // =====================================================================
   // stimulus and observed signals
   localparam logic [31:0] A_NEXT = 32'h0000_1000;
   localparam logic [31:0] A_RND  = 32'h0000_2000;
   localparam logic [31:0] A_NC   = 32'h0000_3000;
   localparam logic [31:0] A_CRIT = 32'h0000_4000;
   localparam logic [31:0] A_RET  = 32'h0000_5000;
   logic        clk_sys_i = 1'b0;
   logic        rst_i     = 1'b1;
   logic [8:0]  ctrl      = 9'h000;
   logic [5:0]  m         = 6'h00;
   logic [5:0]  q         = 6'h00;
   logic [7:0]  pls       = 8'h00;
   logic [2:0]  preq      = 3'h0;
   logic [10:0] clr       = 11'h000;
   logic [2:0]  pins;
   logic [10:0] sts;
   logic [31:0] spc;
   logic        take;
   logic [31:0] last_pc   = 32'h0000_0000;
   int          mismatches = 0;
   int          cmp_count  = 0;

   always #20 clk_sys_i = ~clk_sys_i;

   debug_event_recognition i_debug_event_recognition (
      .clk_sys_i             (clk_sys_i),
      .rst_i                 (rst_i),
      .dbg_ctrl0_i           (ctrl),
      .dbg_irq_allow_i       (m[0]),
      .external_halt_mode_i  (m[1]),
      .internal_dbg_mode_i   (m[2]),
      .dbg_insn_set_en_i     (m[3]),
      .insn_done_i           (pls[0]),
      .insn_suppressed_i     (q[0]),
      .system_call_insn_i    (q[1]),
      .insn_sets_irq_allow_i (q[2]),
      .insn_sets_compl_en_i  (q[3]),
      .next_pc_i             (A_NEXT),
      .fp_round_exc_i        (pls[1]),
      .round_handler_pc_i    (A_RND),
      .nc_intr_i             (pls[2]),
      .nc_handler_pc_i       (A_NC),
      .crit_intr_i           (pls[3]),
      .crit_is_dbg_i         (q[4]),
      .crit_handler_pc_i     (A_CRIT),
      .intr_return_i         (pls[4]),
      .crit_return_i         (pls[5]),
      .ret_pc_i              (A_RET),
      .higher_exc_i          (q[5]),
      .cnt1_on_i             (m[4]),
      .cnt2_on_i             (m[5]),
      .cnt1_zero_i           (pls[6]),
      .cnt2_zero_i           (pls[7]),
      .ext_evt_pin1_i        (pins[0]),
      .ext_evt_pin2_i        (pins[1]),
      .forced_evt_pin_i      (pins[2]),
      .status_clr_i          (clr),
      .dbg_status_o          (sts),
      .dbg_save_pc_o         (spc),
      .dbg_take_o            (take)
   );

   dbg_pin_driver i_dbg_pin_driver (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .req_i     (preq),
      .pin_o     (pins)
   );

   // =====================================================================
   // access tasks
   task final_report;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task set_mode(input logic [8:0] c, input logic [5:0] mm,
                 input logic [5:0] qq);
      @(posedge clk_sys_i);
      ctrl <= c;
      m    <= mm;
      q    <= qq;
   endtask

   // flags must still stand one cycle on, then clear to zero
   task clear(input logic [10:0] es);
      @(posedge clk_sys_i);
      clr <= 11'h7FF;
      #1;
      `CHK("sticky", es, sts)
      `CHK("take_len", 1'b0, take)
      @(posedge clk_sys_i);
      clr <= 11'h000;
      #1;
      `CHK("cleared", 11'h000, sts)
   endtask

   // et of x means the take pulse is not judged in that case
   task go(input logic [7:0] p, input logic [10:0] es, input logic cp,
           input logic [31:0] epc, input logic et);
      @(posedge clk_sys_i);
      pls <= p;
      @(posedge clk_sys_i);
      pls <= 8'h00;
      #1;
      if (cp) last_pc = epc;
      `CHK("status", es, sts)
      `CHK("save_pc", last_pc, spc)
      if (et !== 1'bx) `CHK("take", et, take)
      clear(es);
   endtask

   // pin rises one edge after the request, flag three edges after that
   task pin(input logic [2:0] r, input logic [10:0] es);
      @(posedge clk_sys_i);
      preq <= r;
      @(posedge clk_sys_i);
      preq <= 3'h0;
      repeat (3) @(posedge clk_sys_i);
      #1;
      `CHK("pin_flag", es, sts)
      clear(es);
      repeat (3) @(posedge clk_sys_i);
      #1;
      `CHK("pin_once", 11'h000, sts)
   endtask

   // =====================================================================
   // watchdog: the tests need well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk_sys_i);
      mismatches++;
      final_report;
   end

   initial begin
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      #1;
      `CHK("rst_status", 11'h000, sts)
      `CHK("rst_pc", 32'h0000_0000, spc)
      set_mode(9'h1FF, 6'h01, 6'h00);
      go(8'h01, 11'h001, 1'b1, A_NEXT, 1'b1);
      set_mode(9'h1FE, 6'h01, 6'h00);
      go(8'h01, 11'h000, 1'b0, A_NEXT, 1'b0);
      set_mode(9'h1FF, 6'h00, 6'h00);
      go(8'h01, 11'h000, 1'b0, A_NEXT, 1'b0);
      set_mode(9'h1FF, 6'h02, 6'h00);
      go(8'h01, 11'h001, 1'b1, A_NEXT, 1'b1);
      set_mode(9'h1FF, 6'h01, 6'h01);
      go(8'h01, 11'h000, 1'b0, A_NEXT, 1'b0);
      set_mode(9'h1FF, 6'h01, 6'h03);
      go(8'h01, 11'h001, 1'b1, A_NEXT, 1'b1);
      set_mode(9'h1FF, 6'h01, 6'h04);
      go(8'h01, 11'h000, 1'b0, A_NEXT, 1'b0);
      set_mode(9'h1FF, 6'h02, 6'h08);
      go(8'h01, 11'h000, 1'b0, A_NEXT, 1'b0);
      set_mode(9'h001, 6'h04, 6'h00);
      go(8'h02, 11'h401, 1'b1, A_RND, 1'b1);
      set_mode(9'h001, 6'h02, 6'h00);
      go(8'h02, 11'h401, 1'b1, A_RND, 1'b1);
      set_mode(9'h000, 6'h04, 6'h00);
      go(8'h02, 11'h000, 1'b0, A_RND, 1'b0);
      set_mode(9'h002, 6'h00, 6'h00);
      go(8'h04, 11'h002, 1'b1, A_NC, 1'b0);
      set_mode(9'h004, 6'h08, 6'h10);
      go(8'h08, 11'h004, 1'b1, A_CRIT, 1'b0);
      set_mode(9'h004, 6'h00, 6'h10);
      go(8'h08, 11'h000, 1'b0, A_CRIT, 1'b0);
      set_mode(9'h008, 6'h01, 6'h20);
      go(8'h10, 11'h008, 1'b0, A_RET, 1'b0);
      set_mode(9'h008, 6'h00, 6'h00);
      go(8'h10, 11'h408, 1'b0, A_RET, 1'b0);
      set_mode(9'h008, 6'h01, 6'h00);
      go(8'h10, 11'h008, 1'b1, A_RET, 1'b1);
      set_mode(9'h060, 6'h30, 6'h00);
      go(8'hC0, 11'h060, 1'b0, A_RET, 1'b0);
      set_mode(9'h060, 6'h10, 6'h00);
      go(8'hC0, 11'h020, 1'b0, A_RET, 1'b0);
      set_mode(9'h022, 6'h10, 6'h00);
      go(8'h44, 11'h022, 1'b1, A_NC, 1'b0);
      set_mode(9'h010, 6'h01, 6'h20);
      go(8'h20, 11'h010, 1'b0, A_RET, 1'b0);
      set_mode(9'h010, 6'h00, 6'h00);
      go(8'h20, 11'h410, 1'b0, A_RET, 1'b0);
      set_mode(9'h010, 6'h01, 6'h00);
      go(8'h20, 11'h010, 1'b1, A_RET, 1'b1);
      set_mode(9'h180, 6'h00, 6'h00);
      pin(3'h1, 11'h080);
      pin(3'h2, 11'h100);
      set_mode(9'h000, 6'h00, 6'h00);
      pin(3'h3, 11'h000);
      set_mode(9'h000, 6'h04, 6'h00);
      pin(3'h4, 11'h200);
      set_mode(9'h000, 6'h02, 6'h00);
      pin(3'h4, 11'h200);
      set_mode(9'h1FF, 6'h01, 6'h00);
      pin(3'h4, 11'h000);
      final_report;
   end
endmodule // debug_event_recognition_bench

`default_nettype wire
